// ===== copy_engine.sv
// Byte copy engine that moves nonvolatile bytes into registers, one byte per step.
`timescale 1ns/1ps
module copy_engine (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic start_in,
   input wire loader_pkg::copy_job_t job_in,
   input wire logic [7:0] nv_data_in,
   output logic busy_out,
   output logic done_out,
   output logic nv_rd_out,
   output logic [12:0] nv_addr_out,
   output loader_pkg::reg_write_t reg_wr_out,
   output logic byte_valid_out
);

   typedef enum logic [1:0] {
      EN_IDLE = 2'b00,
      EN_READ = 2'b01,
      EN_WRITE = 2'b10
   } eng_state_t;

   eng_state_t state;
   eng_state_t next_state;
   loader_pkg::copy_job_t job;
   loader_pkg::copy_job_t next_job;
   logic [7:0] idx;
   logic [7:0] next_idx;
   logic next_busy;
   logic next_done;
   logic next_rd;
   logic [12:0] next_addr;
   loader_pkg::reg_write_t next_wr;
   logic next_byte_valid;

   // Read in one step, write the returned byte in the next; the data is valid the cycle after the read.
   always_comb begin
      next_state = state;
      next_job = job;
      next_idx = idx;
      next_busy = busy_out;
      next_done = 1'b0;
      next_rd = 1'b0;
      next_addr = nv_addr_out;
      next_wr = '0;
      next_byte_valid = 1'b0;
      case (state)
         EN_IDLE: begin
            if (start_in) begin
               next_job = job_in;
               next_idx = 8'h00;
               next_busy = 1'b1;
               next_rd = 1'b1;
               next_addr = job_in.src;
               next_state = EN_READ;
            end
         end
         EN_READ: begin
            next_state = EN_WRITE;
         end
         EN_WRITE: begin
            // Each byte goes out with its writable-bit mask, so protected bits keep their value.
            next_wr.en = job.to_regs;
            next_wr.addr = job.dst + idx[6:0];
            next_wr.data = nv_data_in;
            next_wr.mask = loader_pkg::rw_mask(job.dst + idx[6:0]);
            next_byte_valid = 1'b1;
            if (idx == job.len - 8'h01) begin
               next_done = 1'b1;
               next_busy = 1'b0;
               next_state = EN_IDLE;
            end else begin
               next_idx = idx + 8'h01;
               next_rd = 1'b1;
               next_addr = nv_addr_out + 13'h0001; // One register per step, in order.
               next_state = EN_READ;
            end
         end
         default: next_state = EN_IDLE;
      endcase
   end

   // Registers of the engine.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state <= EN_IDLE;
         job <= '0;
         idx <= 8'h00;
         busy_out <= 1'b0;
         done_out <= 1'b0;
         nv_rd_out <= 1'b0;
         nv_addr_out <= 13'h0000;
         reg_wr_out <= '0;
         byte_valid_out <= 1'b0;
      end else begin
         state <= next_state;
         job <= next_job;
         idx <= next_idx;
         busy_out <= next_busy;
         done_out <= next_done;
         nv_rd_out <= next_rd;
         nv_addr_out <= next_addr;
         reg_wr_out <= next_wr;
         byte_valid_out <= next_byte_valid;
      end
   end

endmodule // copy_engine

// ===== eeprom_register_init_loader.sv
// Top of the loader: startup copy, protocol preset load and user settings copy.
`timescale 1ns/1ps
module eeprom_register_init_loader (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [7:0] nv_data_in,
   input wire logic protocol_preset_load_cmd_in,
   input wire logic [5:0] tx_protocol_in,
   input wire logic [5:0] rx_protocol_in,
   input wire logic user_settings_copy_cmd_in,
   input wire logic [12:0] user_src_in,
   input wire logic [6:0] user_dst_in,
   input wire logic [7:0] user_len_in,
   output logic nv_rd_out,
   output logic [12:0] nv_addr_out,
   output loader_pkg::reg_write_t reg_wr_out,
   output logic host_block_out,
   output logic [6:0] secure_module_bus_address_out,
   output logic [7:0] tx_crc_start_value_out,
   output logic cmd_done_out,
   output logic cmd_error_out
);

   typedef enum logic [2:0] {
      ST_BOOT = 3'b000,
      ST_CFG = 3'b001,
      ST_RESET_COPY = 3'b010,
      ST_RUN = 3'b011,
      ST_TX = 3'b100,
      ST_RX = 3'b101,
      ST_USER = 3'b110
   } top_state_t;

   top_state_t state;
   top_state_t next_state;
   logic start;
   logic next_start;
   loader_pkg::copy_job_t job;
   loader_pkg::copy_job_t next_job;
   logic [5:0] rx_sel;
   logic [5:0] next_rx_sel;
   logic next_block;
   logic [6:0] next_sam;
   logic [7:0] next_crc;
   logic next_cmd_done;
   logic next_cmd_error;
   logic eng_busy;
   logic eng_done;
   logic byte_valid;
   logic load_ok;
   logic user_ok;
   logic [8:0] user_end;

   // The engine's read and register write outputs are flip-flops, so they reach the top ports unchanged.
   copy_engine u_engine (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .start_in(start),
      .job_in(job),
      .nv_data_in(nv_data_in),
      .busy_out(eng_busy),
      .done_out(eng_done),
      .nv_rd_out(nv_rd_out),
      .nv_addr_out(nv_addr_out),
      .reg_wr_out(reg_wr_out),
      .byte_valid_out(byte_valid)
   );

   // Protocol selections beyond the stored set are refused rather than reading past the area.
   assign load_ok = (tx_protocol_in < loader_pkg::PROTO_COUNT) && (rx_protocol_in < loader_pkg::PROTO_COUNT);
   assign user_end = {2'b00, user_dst_in} + {1'b0, user_len_in};
   assign user_ok = (user_len_in != 8'h00) && (user_end <= {1'b0, loader_pkg::REG_COUNT});

   // Sequencing of startup and commands; commands arrive only while running.
   always_comb begin
      next_state = state;
      next_start = 1'b0;
      next_job = job;
      next_rx_sel = rx_sel;
      next_sam = secure_module_bus_address_out;
      next_crc = tx_crc_start_value_out;
      next_cmd_done = 1'b0;
      next_cmd_error = 1'b0;
      case (state)
         ST_BOOT: begin
            // Configuration bytes of page zero are fetched first, but not written to registers.
            next_job = '{src: loader_pkg::CFG_BASE, dst: 7'h00, len: loader_pkg::CFG_LEN, to_regs: 1'b0};
            next_start = 1'b1;
            next_state = ST_CFG;
         end
         ST_CFG: begin
            if (byte_valid && reg_wr_out.addr == loader_pkg::SAM_ADDR_OFS) begin
               next_sam = reg_wr_out.data[6:0]; // Bus address only ever from the stored byte.
            end
            if (byte_valid && reg_wr_out.addr == loader_pkg::TX_CRC_OFS) begin
               next_crc = reg_wr_out.data; // CRC generator seed.
            end
            if (eng_done) begin
               // Reset area is copied in register order on every startup.
               next_job = '{src: loader_pkg::RESET_BASE, dst: 7'h00, len: loader_pkg::REG_COUNT, to_regs: 1'b1};
               next_start = 1'b1;
               next_state = ST_RESET_COPY;
            end
         end
         ST_RESET_COPY: begin
            if (eng_done) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (protocol_preset_load_cmd_in) begin
               if (load_ok) begin
                  // Transmit part first, then receive part, from the read-only area.
                  next_job.src = loader_pkg::RSP_BASE + 13'(tx_protocol_in) * loader_pkg::RSP_STRIDE;
                  next_job.dst = loader_pkg::TX_DST;
                  next_job.len = loader_pkg::RSP_TX_LEN;
                  next_job.to_regs = 1'b1;
                  next_rx_sel = rx_protocol_in;
                  next_start = 1'b1;
                  next_state = ST_TX;
               end else begin
                  next_cmd_error = 1'b1;
               end
            end else if (user_settings_copy_cmd_in) begin
               if (user_ok) begin
                  // The user chooses the source address of the copy.
                  next_job = '{src: user_src_in, dst: user_dst_in, len: user_len_in, to_regs: 1'b1};
                  next_start = 1'b1;
                  next_state = ST_USER;
               end else begin
                  next_cmd_error = 1'b1;
               end
            end
         end
         ST_TX: begin
            if (eng_done) begin
               next_job.src = loader_pkg::RSP_BASE + 13'(rx_sel) * loader_pkg::RSP_STRIDE
                  + 13'(loader_pkg::RSP_TX_LEN);
               next_job.dst = loader_pkg::RX_DST;
               next_job.len = loader_pkg::RSP_RX_LEN;
               next_job.to_regs = 1'b1;
               next_start = 1'b1;
               next_state = ST_RX;
            end
         end
         ST_RX, ST_USER: begin
            if (eng_done) begin
               next_cmd_done = 1'b1;
               next_state = ST_RUN;
            end
         end
         default: next_state = ST_BOOT;
      endcase
      // Host accesses stay blocked for the whole of any copy.
      next_block = (next_state != ST_RUN);
   end

   // Registers of the sequencer.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state <= ST_BOOT;
         start <= 1'b0;
         job <= '0;
         rx_sel <= 6'h00;
         host_block_out <= 1'b1;
         secure_module_bus_address_out <= loader_pkg::SAM_ADDR_RESET;
         tx_crc_start_value_out <= loader_pkg::TX_CRC_RESET;
         cmd_done_out <= 1'b0;
         cmd_error_out <= 1'b0;
      end else begin
         state <= next_state;
         start <= next_start;
         job <= next_job;
         rx_sel <= next_rx_sel;
         host_block_out <= next_block;
         secure_module_bus_address_out <= next_sam;
         tx_crc_start_value_out <= next_crc;
         cmd_done_out <= next_cmd_done;
         cmd_error_out <= next_cmd_error;
      end
   end

   // The bus address changes only when its stored byte has just been read.
   AST_SAM_FROM_NV: assert property (@(posedge clk_in) disable iff (rst_in)
      $changed(secure_module_bus_address_out) |-> $past(state) == ST_CFG && $past(byte_valid)
         && $past(reg_wr_out.addr) == loader_pkg::SAM_ADDR_OFS)
      else $error("secure module address changed without its stored byte");

   // A transmit preset writes only into the sixteen transmit registers.
   AST_TX_SPAN: assert property (@(posedge clk_in) disable iff (rst_in)
      state == ST_TX && reg_wr_out.en |-> reg_wr_out.addr >= loader_pkg::TX_DST
         && reg_wr_out.addr < loader_pkg::TX_DST + 7'h10)
      else $error("transmit preset wrote outside its registers");

   // The CRC seed changes only from its stored byte.
   AST_CRC_PRESET: assert property (@(posedge clk_in) disable iff (rst_in)
      $changed(tx_crc_start_value_out) |-> $past(byte_valid)
         && $past(reg_wr_out.addr) == loader_pkg::TX_CRC_OFS && $past(state) == ST_CFG)
      else $error("crc seed changed without its stored byte");

   // Registers 0x42 and 0x49 receive an empty write mask.
   AST_RO_MASK: assert property (@(posedge clk_in) disable iff (rst_in)
      reg_wr_out.en && (reg_wr_out.addr == 7'h49 || reg_wr_out.addr == 7'h42) |-> reg_wr_out.mask == 8'h00)
      else $error("protected register given a write mask");

   // An accepted user copy reads first from the address the user gave.
   AST_USER_SRC: assert property (@(posedge clk_in) disable iff (rst_in)
      state == ST_RUN && !protocol_preset_load_cmd_in && user_settings_copy_cmd_in && user_ok
         |=> state == ST_USER ##1 nv_rd_out && nv_addr_out == $past(user_src_in, 2))
      else $error("user copy did not start at the given address");

   // After the configuration bytes, the reset area copy begins at its base address.
   AST_BOOT_COPY: assert property (@(posedge clk_in) disable iff (rst_in)
      state == ST_CFG && eng_done |=> state == ST_RESET_COPY ##1 nv_rd_out
         && nv_addr_out == loader_pkg::RESET_BASE)
      else $error("reset area copy did not start at its base");

   // An accepted protocol load reads the selected transmit record first.
   AST_PROTO_START: assert property (@(posedge clk_in) disable iff (rst_in)
      state == ST_RUN && protocol_preset_load_cmd_in && load_ok |=> state == ST_TX ##1 nv_rd_out
         && nv_addr_out == loader_pkg::RSP_BASE + 13'($past(tx_protocol_in, 2)) * loader_pkg::RSP_STRIDE)
      else $error("protocol load read the wrong record");

   // Each reset byte lands on the register of the same position in the area.
   AST_REG_ORDER: assert property (@(posedge clk_in) disable iff (rst_in)
      state == ST_RESET_COPY && reg_wr_out.en |-> reg_wr_out.addr
         == 7'($past(nv_addr_out, 2) - loader_pkg::RESET_BASE))
      else $error("reset byte written out of register order");

   // Configuration reads stay inside page zero.
   AST_CFG_PAGE0: assert property (@(posedge clk_in) disable iff (rst_in)
      state == ST_CFG && nv_rd_out |-> nv_addr_out < loader_pkg::NV_PAGE_BYTES)
      else $error("configuration read outside page zero");

   // The host stays blocked while any copy is under way.
   AST_HOST_BLOCK: assert property (@(posedge clk_in) disable iff (rst_in)
      eng_busy |-> host_block_out)
      else $error("host unblocked during a copy");

endmodule // eeprom_register_init_loader

// ===== eeprom_register_init_loader_tb_top.sv
// Self-checking testbench of the register initialisation loader.
`timescale 1ns/1ps
module eeprom_register_init_loader_tb_top;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [7:0] nv_data_in;
   logic protocol_preset_load_cmd_in = 1'b0;
   logic [5:0] tx_protocol_in = 6'h00;
   logic [5:0] rx_protocol_in = 6'h00;
   logic user_settings_copy_cmd_in = 1'b0;
   logic [12:0] user_src_in = 13'h0000;
   logic [6:0] user_dst_in = 7'h00;
   logic [7:0] user_len_in = 8'h00;
   logic nv_rd_out;
   logic [12:0] nv_addr_out;
   loader_pkg::reg_write_t reg_wr_out;
   logic host_block_out;
   logic [6:0] secure_module_bus_address_out;
   logic [7:0] tx_crc_start_value_out;
   logic cmd_done_out;
   logic cmd_error_out;
   logic [7:0] regs [0:127];
   int rd_count = 0;
   int err_total = 0;
   int checked = 0;

   // A 5 ns period gives the 200 MHz system clock.
   always #2.5 clk_in = ~clk_in;

   eeprom_register_init_loader i_dut (.clk_in(clk_in), .rst_in(rst_in), .nv_data_in(nv_data_in),
      .protocol_preset_load_cmd_in(protocol_preset_load_cmd_in), .tx_protocol_in(tx_protocol_in),
      .rx_protocol_in(rx_protocol_in), .user_settings_copy_cmd_in(user_settings_copy_cmd_in),
      .user_src_in(user_src_in), .user_dst_in(user_dst_in), .user_len_in(user_len_in),
      .nv_rd_out(nv_rd_out), .nv_addr_out(nv_addr_out), .reg_wr_out(reg_wr_out),
      .host_block_out(host_block_out), .secure_module_bus_address_out(secure_module_bus_address_out),
      .tx_crc_start_value_out(tx_crc_start_value_out), .cmd_done_out(cmd_done_out),
      .cmd_error_out(cmd_error_out));

   nv_memory_model i_mem (.clk_in(clk_in), .nv_rd_in(nv_rd_out), .nv_addr_in(nv_addr_out),
      .nv_data_out(nv_data_in));

   // Shadow register file: only bits whose mask is set take the written data, as a real register would.
   always @(posedge clk_in) begin
      if (!rst_in && reg_wr_out.en === 1'b1) begin
         for (int b = 0; b < 8; b++) begin
            if (reg_wr_out.mask[b]) regs[reg_wr_out.addr][b] = reg_wr_out.data[b];
         end
      end
      if (!rst_in && nv_rd_out === 1'b1) rd_count++;
   end

   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Registers that hold no writable bits; a copy must leave them as they were.
   function automatic logic locked(input int r);
      return r == 'h3A || r == 'h42 || r == 'h43 || r == 'h49 || r >= 'h60;
   endfunction

   // Waits under a bound for the host block to drop and reports the done flag of that cycle.
   task automatic wait_idle(output logic done);
      int n;
      n = 0;
      @(negedge clk_in);
      while (host_block_out !== 1'b0 && n < 2000) begin
         @(negedge clk_in);
         n++;
      end
      if (n >= 2000) check(16'h0001, 16'h0000);
      done = cmd_done_out;
   endtask

   // Holds reset for 20 cycles, then lets the startup copy run to its end.
   task automatic do_reset;
      logic done;
      @(negedge clk_in);
      rst_in = 1'b1;
      repeat (20) @(negedge clk_in);
      for (int i = 0; i < 128; i++) regs[i] = 8'hAA;
      rd_count = 0;
      rst_in = 1'b0;
      repeat (3) @(negedge clk_in);
      check(host_block_out, 1'b1);
      wait_idle(done);
   endtask

   // Startup copy: configuration bytes, then one reset byte per register in register order.
   task automatic t_startup;
      do_reset();
      check(rd_count, 104);
      for (int i = 0; i < 96; i++) begin
         check(regs[i], locked(i) ? 8'hAA : i_mem.mem[13'h0040 + i]);
      end
      check(regs[2], 8'h80);
      check(regs[3], 8'h05);
      check(secure_module_bus_address_out, i_mem.mem[13'h0022][6:0]);
      check(tx_crc_start_value_out, i_mem.mem[13'h0026]);
   endtask

   // Protocol preset load: 16 transmit bytes, then the 8 receive bytes of the receive record.
   task automatic t_load(input logic [5:0] tx, input logic [5:0] rx);
      logic done;
      @(negedge clk_in);
      tx_protocol_in = tx;
      rx_protocol_in = rx;
      protocol_preset_load_cmd_in = 1'b1;
      rd_count = 0;
      @(negedge clk_in);
      protocol_preset_load_cmd_in = 1'b0;
      check(host_block_out, 1'b1);
      wait_idle(done);
      check(done, 1'b1);
      check(rd_count, 24);
      for (int i = 0; i < 16; i++) check(regs['h28 + i], i_mem.mem[13'h1C00 + 24 * tx + i]);
      for (int i = 0; i < 8; i++) check(regs['h58 + i], i_mem.mem[13'h1C00 + 24 * rx + 16 + i]);
   endtask

   // User settings copy from a given source address to a register range that ends within the 96 registers.
   task automatic t_user(input logic [12:0] src, input logic [6:0] dst, input logic [7:0] len);
      logic done;
      @(negedge clk_in);
      user_src_in = src;
      user_dst_in = dst;
      user_len_in = len;
      user_settings_copy_cmd_in = 1'b1;
      rd_count = 0;
      @(negedge clk_in);
      user_settings_copy_cmd_in = 1'b0;
      wait_idle(done);
      check(done, 1'b1);
      check(rd_count, len);
      for (int i = 0; i < len; i++) check(regs[dst + i], i_mem.mem[src + i]);
   endtask

   // A refused command gives one error pulse and never touches memory.
   task automatic t_refuse(input logic load, input logic [5:0] tx, input logic [5:0] rx, input logic [6:0] dst,
                           input logic [7:0] len);
      int errs;
      int dones;
      errs = 0;
      dones = 0;
      @(negedge clk_in);
      tx_protocol_in = tx;
      rx_protocol_in = rx;
      user_dst_in = dst;
      user_len_in = len;
      protocol_preset_load_cmd_in = load;
      user_settings_copy_cmd_in = !load;
      rd_count = 0;
      for (int i = 0; i < 6; i++) begin
         @(negedge clk_in);
         protocol_preset_load_cmd_in = 1'b0;
         user_settings_copy_cmd_in = 1'b0;
         if (cmd_error_out === 1'b1) errs++;
         if (cmd_done_out === 1'b1) dones++;
      end
      check(errs, 1);
      check(dones, 0);
      check(rd_count, 0);
   endtask

   // Rewritten stored defaults must become the configuration at the next startup.
   task automatic t_rewrite;
      i_mem.mem[13'h0042] = 8'h33;
      i_mem.mem[13'h0022] = 8'h95;
      do_reset();
      check(regs[2], 8'h33);
      check(secure_module_bus_address_out, 7'h15);
   endtask

   initial begin
      // Every byte differs from its neighbours so a shifted address shows up.
      for (int a = 0; a < 8192; a++) i_mem.mem[a] = a[7:0] ^ {3'b000, a[12:8]} ^ 8'h5A;
      i_mem.mem[13'h0042] = 8'h80;
      i_mem.mem[13'h0043] = 8'h05;
      t_startup();
      t_load(6'd0, 6'd41);
      t_load(6'd41, 6'd0);
      t_load(6'd7, 6'd3);
      t_user(13'h00C0, 7'h10, 8'h04);
      t_user(13'h1FF8, 7'h5C, 8'h04);
      t_refuse(1'b1, 6'd42, 6'd0, 7'h00, 8'h00);
      t_refuse(1'b1, 6'd0, 6'd63, 7'h00, 8'h00);
      t_refuse(1'b0, 6'd0, 6'd0, 7'h10, 8'h00);
      t_refuse(1'b0, 6'd0, 6'd0, 7'h5E, 8'h03);
      t_rewrite();
      close_out();
   end

   // The whole sequence needs well under 2,000 cycles; a hang is cut off long after that.
   initial begin
      repeat (20000) @(posedge clk_in);
      err_total++;
      close_out();
   end
endmodule // eeprom_register_init_loader_tb_top

// ===== loader_pkg.sv
// Package with constants, types and decoding shared by the register initialisation loader.
// Functional notes
// - Secure-module bus address always comes from the stored configuration byte, never pins.
// - Each stored protocol holds 16 transmit bytes and 8 receive bytes.
// - Transmit CRC generator start value is taken from the stored CRC preset byte.
// - A default copy only alters read/write or dynamic bits; others stay untouched.
// - Copy source addresses depend on protocol selection and can be set by the user.
// - Stored reset bytes become the configuration after startup; rewriting them changes defaults.
// - A protocol load command overwrites registers with a selected stored protocol.
// - Reset area holds one default byte per register, in register order.
// - Page zero holds identification, version, unique number and trim values from production.
// - At startup the reset area is copied into the registers before normal operation.
// - Protocol load copies from the read-only protocol settings area.
// - Nonvolatile memory is organised in pages of 64 bytes.
package loader_pkg;

   localparam int NV_AW = 13;
   localparam int RA_W = 7;

   // Memory layout in bytes.
   localparam logic [12:0] NV_PAGE_BYTES = 13'h0040;
   localparam logic [12:0] CFG_BASE = 13'h0020;
   localparam logic [7:0] CFG_LEN = 8'h08;
   localparam logic [6:0] SAM_ADDR_OFS = 7'h02;
   localparam logic [6:0] TX_CRC_OFS = 7'h06;
   localparam logic [12:0] RESET_BASE = 13'h0040;
   localparam logic [7:0] REG_COUNT = 8'h60;
   localparam logic [12:0] RSP_BASE = 13'h1C00;
   localparam logic [7:0] RSP_TX_LEN = 8'h10;
   localparam logic [7:0] RSP_RX_LEN = 8'h08;
   localparam logic [12:0] RSP_STRIDE = 13'h0018;
   localparam logic [5:0] PROTO_COUNT = 6'h2A;
   localparam logic [6:0] TX_DST = 7'h28;
   localparam logic [6:0] RX_DST = 7'h58;

   // Register indices and stored defaults quoted for reference.
   localparam logic [6:0] BUFFER_CONTROL_IDX = 7'h02;
   localparam logic [6:0] BUFFER_THRESHOLD_IDX = 7'h03;
   localparam logic [7:0] BUFFER_CONTROL_DEFAULT = 8'h80;
   localparam logic [7:0] BUFFER_THRESHOLD_DEFAULT = 8'h05;

   // Output values after reset.
   localparam logic [6:0] SAM_ADDR_RESET = 7'h00;
   localparam logic [7:0] TX_CRC_RESET = 8'h00;

   typedef struct packed {
      logic [12:0] src;
      logic [6:0] dst;
      logic [7:0] len;
      logic to_regs;
   } copy_job_t;

   typedef struct packed {
      logic en;
      logic [6:0] addr;
      logic [7:0] data;
      logic [7:0] mask;
   } reg_write_t;

   // Writable bit mask of a register; reserved and read-only registers take no copy.
   function automatic logic [7:0] rw_mask(input logic [6:0] a);
      logic [7:0] m;
      m = 8'hFF;
      case (a)
         7'h3A: m = 8'h00;
         7'h42: m = 8'h00;
         7'h43: m = 8'h00;
         7'h49: m = 8'h00;
         default: m = (a < REG_COUNT[6:0]) ? 8'hFF : 8'h00;
      endcase
      return m;
   endfunction

endpackage

// ===== nv_memory_model.sv
// Behavioural nonvolatile memory that answers the loader's reads one cycle later.
`timescale 1ns/1ps
module nv_memory_model (
   input wire logic clk_in,
   input wire logic nv_rd_in,
   input wire logic [12:0] nv_addr_in,
   output logic [7:0] nv_data_out
);
   // The array is held as one flat run of 8192 bytes; the bench fills and rewrites it by hierarchy.
   logic [7:0] mem [0:8191];
   logic [7:0] last = 8'h00;
   logic answer = 1'b0;

   // The read byte stands only in the cycle after the read, page zero, reset area and protocol area alike.
   // Outside that cycle the inverse of the last byte shows, so a late sample never matches by luck.
   always @(posedge clk_in) begin
      answer <= nv_rd_in;
      if (nv_rd_in) begin
         last <= mem[nv_addr_in];
      end
   end

   assign nv_data_out = answer ? last : ~last;
endmodule // nv_memory_model
